// >>> plsc_pkg.sv
// Package: constants, enums and carriers of the power load shed controller
`default_nettype none
package plsc_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [7:0] STARTUP_SEC = 8'h78;
    localparam logic [7:0] HOLD_SEC = 8'h78;
    localparam int NUM_LOADS = 6;
    // ************************************************************
    // Current limits in amps
    // ************************************************************
    localparam logic [7:0] LIM_SHORE_HI = 8'h1e;
    localparam logic [7:0] LIM_SHORE_LO = 8'h14;
    localparam logic [7:0] LIM_GEN_LO = 8'h2d;
    localparam logic [7:0] LIM_GEN_HI = 8'h3c;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LOADS = 8'h08;
    localparam logic [7:0] OFS_LEARN = 8'h10;
    localparam int CTRL_GEN_EMS_BIT = 0;
    localparam int CTRL_GEN_HI_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_SHORE = 2'b01,
        SRC_GEN = 2'b10,
        SRC_SPLIT = 2'b11
    } plsc_src_e;
    typedef enum logic [1:0] {
        ST_DELAY = 2'b00,
        ST_RAMP = 2'b01,
        ST_RUN = 2'b10
    } plsc_state_e;
    typedef enum logic [1:0] {
        MTR_CURRENT = 2'b00,
        MTR_BLANK = 2'b01,
        MTR_SPIN = 2'b10
    } plsc_meter_e;
    typedef struct packed {
        logic line_one_input;
        logic line_two_input;
        logic lines_in_phase;
        logic generator_running_input;
    } plsc_line_s;
    typedef struct packed {
        plsc_meter_e meter_mode;
        logic [7:0] meter_value;
        logic [2:0] spin_phase;
        logic led_gen;
        logic led_fifty;
        logic led_thirty_twenty;
        logic [5:0] power_leds;
    } plsc_display_s;
endpackage
`default_nettype wire

// >>> plsc_ctrl.sv
// Power load shed controller: source sensing, load sequencing, shedding, AHB-Lite registers
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Manage loads only without split-phase service
// - Split-phase service: all relays closed after the ramp
// - Shed loads when neutral current exceeds limit
// - Six load outputs, four line, two low-voltage
// - Two-minute all-off delay after power-up
// - Source change drops loads, restarts delay
// - Meter shows rotating segments during delay
// - After delay, loads on one per second
// - Generator input classifies generator service
// - Split-phase: blank meter, all lights, service LED only while the generator input is low
// - Same phase plus generator: current, generator LED
// - Generator, management off: all loads, all lights
// - Single phase, no generator: 30 A shore
// - Button toggles 20 A limit on shore
// - Link good lit, link fault dark
// - Shed in table order, learn each drop
// - Hold shed load two minutes, flash, restore
// - Restore last shed when headroom covers learned
module plsc_ctrl #(
    parameter int TICK_CYCLES = plsc_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire plsc_pkg::plsc_line_s lines,
    input wire logic [7:0] current_amps,
    input wire logic service_select_pulse,
    output logic [5:0] relay_drive,
    output plsc_pkg::plsc_display_s display,
    output logic link_good_indicator,
    output logic link_fault_indicator
);
    import plsc_pkg::*;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic plsc_src_e classify(input plsc_line_s s);
        if (!s.line_one_input && !s.line_two_input) begin
            classify = SRC_NONE;
        end else if (s.line_one_input && s.line_two_input && !s.lines_in_phase) begin
            classify = SRC_SPLIT;
        end else if (s.generator_running_input) begin
            classify = SRC_GEN;
        end else begin
            classify = SRC_SHORE;
        end
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [23:0] tick_cnt_reg;
    logic tick_reg;
    logic blink_reg;
    plsc_src_e src_reg;
    plsc_src_e src_next;
    logic src_change;
    plsc_state_e state_reg;
    logic [7:0] sec_reg;
    logic [2:0] ramp_idx_reg;
    logic [5:0] relay_reg;
    logic [2:0] shed_cnt_reg;
    logic limit20_reg;
    logic [1:0] ctrl_reg;
    logic [7:0] hold_reg [NUM_LOADS];
    logic [7:0] learn_reg [NUM_LOADS];
    logic learn_pend_reg;
    logic [2:0] learn_idx_reg;
    logic [7:0] before_reg;
    logic managed;
    logic [7:0] limit;
    logic over;
    logic [7:0] headroom;
    logic [2:0] top_idx;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;

    assign src_next = classify(lines);
    assign src_change = src_next != src_reg;
    assign managed = (src_reg == SRC_SHORE) || (src_reg == SRC_GEN && ctrl_reg[CTRL_GEN_EMS_BIT]);
    assign over = current_amps > limit;
    assign headroom = over ? 8'h00 : limit - current_amps;
    assign top_idx = shed_cnt_reg - 3'h1;

    always_comb begin
        if (src_reg == SRC_GEN) begin
            limit = ctrl_reg[CTRL_GEN_HI_BIT] ? LIM_GEN_HI : LIM_GEN_LO;
        end else begin
            limit = limit20_reg ? LIM_SHORE_LO : LIM_SHORE_HI;
        end
    end

    // ************************************************************
    // Timebase
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_reg <= 24'h000000;
            tick_reg <= 1'b0;
            blink_reg <= 1'b0;
        end else if (tick_cnt_reg == 24'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 24'h000000;
            tick_reg <= 1'b1;
            blink_reg <= !blink_reg;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 24'h000001;
            tick_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Source and sequencing
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_reg <= SRC_NONE;
        end else begin
            src_reg <= src_next;
        end
    end

    // Reset and source change both land in the delay state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_DELAY;
            sec_reg <= 8'h00;
            ramp_idx_reg <= 3'h0;
        end else if (src_change || src_reg == SRC_NONE) begin
            state_reg <= ST_DELAY;
            sec_reg <= 8'h00;
            ramp_idx_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_DELAY: begin
                    if (tick_reg && sec_reg == STARTUP_SEC - 8'h01) begin
                        state_reg <= ST_RAMP;
                    end else if (tick_reg) begin
                        sec_reg <= sec_reg + 8'h01;
                    end
                end
                ST_RAMP: begin
                    if (tick_reg) begin
                        ramp_idx_reg <= ramp_idx_reg + 3'h1;
                        if (ramp_idx_reg == 3'(NUM_LOADS - 1)) begin
                            state_reg <= ST_RUN;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            limit20_reg <= 1'b0;
        end else if (src_change || src_reg != SRC_SHORE) begin
            limit20_reg <= 1'b0;
        end else if (service_select_pulse) begin
            limit20_reg <= !limit20_reg;
        end
    end

    // ************************************************************
    // Relays, shedding and restore
    // ************************************************************
    // One shed or restore per tick so the next tick sees the settled current
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            relay_reg <= 6'h00;
            shed_cnt_reg <= 3'h0;
            learn_pend_reg <= 1'b0;
            learn_idx_reg <= 3'h0;
            before_reg <= 8'h00;
            for (int i = 0; i < NUM_LOADS; i++) begin
                hold_reg[i] <= 8'h00;
            end
        end else if (src_change || src_reg == SRC_NONE || state_reg == ST_DELAY) begin
            relay_reg <= 6'h00;
            shed_cnt_reg <= 3'h0;
            learn_pend_reg <= 1'b0;
            for (int i = 0; i < NUM_LOADS; i++) begin
                hold_reg[i] <= 8'h00;
            end
        end else if (state_reg == ST_RAMP) begin
            if (tick_reg) begin
                relay_reg[ramp_idx_reg] <= 1'b1;
            end
        end else if (!managed) begin
            relay_reg <= 6'h3f;
            shed_cnt_reg <= 3'h0;
            learn_pend_reg <= 1'b0;
            for (int i = 0; i < NUM_LOADS; i++) begin
                hold_reg[i] <= 8'h00;
            end
        end else if (tick_reg) begin
            for (int i = 0; i < NUM_LOADS; i++) begin
                if (hold_reg[i] != 8'h00) begin
                    hold_reg[i] <= hold_reg[i] - 8'h01;
                end
            end
            learn_pend_reg <= 1'b0;
            if (over && shed_cnt_reg != 3'(NUM_LOADS)) begin
                relay_reg[shed_cnt_reg] <= 1'b0;
                hold_reg[shed_cnt_reg] <= HOLD_SEC;
                learn_idx_reg <= shed_cnt_reg;
                before_reg <= current_amps;
                learn_pend_reg <= 1'b1;
                shed_cnt_reg <= shed_cnt_reg + 3'h1;
            end else if (!over && shed_cnt_reg != 3'h0 && hold_reg[top_idx] == 8'h00
                         && headroom >= learn_reg[top_idx]) begin
                relay_reg[top_idx] <= 1'b1;
                shed_cnt_reg <= top_idx;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_LOADS; i++) begin
                learn_reg[i] <= 8'h00;
            end
        end else if (tick_reg && learn_pend_reg) begin
            learn_reg[learn_idx_reg] <= (before_reg > current_amps) ? before_reg - current_amps : 8'h00;
        end
    end

    // ************************************************************
    // Display and indicators
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            display <= '0;
            link_good_indicator <= 1'b0;
            link_fault_indicator <= 1'b0;
        end else begin
            link_good_indicator <= 1'b1;
            link_fault_indicator <= 1'b0;
            display.meter_value <= current_amps;
            if (tick_reg) begin
                display.spin_phase <= (display.spin_phase == 3'h5) ? 3'h0 : display.spin_phase + 3'h1;
            end
            if (state_reg == ST_DELAY) begin
                display.meter_mode <= MTR_SPIN;
            end else if (src_reg == SRC_SPLIT) begin
                display.meter_mode <= MTR_BLANK;
            end else begin
                display.meter_mode <= MTR_CURRENT;
            end
            display.led_gen <= lines.generator_running_input && src_reg != SRC_NONE;
            display.led_fifty <= src_reg == SRC_SPLIT && !lines.generator_running_input;
            display.led_thirty_twenty <= src_reg == SRC_SHORE;
            if (state_reg == ST_RUN && !managed) begin
                display.power_leds <= 6'h3f;
            end else begin
                for (int i = 0; i < NUM_LOADS; i++) begin
                    display.power_leds[i] <= relay_reg[i]
                        || (hold_reg[i] != 8'h00 && headroom >= learn_reg[i] && blink_reg);
                end
            end
        end
    end

    assign relay_drive = relay_reg;

    // ************************************************************
    // AHB-Lite slave, zero wait states
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
            wr_addr_reg <= haddr[7:0];
            hrdata <= 32'h00000000;
            if (hsel && htrans[1] && hready && !hwrite) begin
                if (haddr[7:0] == OFS_CTRL) begin
                    hrdata <= {30'h00000000, ctrl_reg};
                end else if (haddr[7:0] == OFS_STATUS) begin
                    hrdata <= {18'h00000, limit20_reg, over, state_reg, src_reg, current_amps};
                end else if (haddr[7:0] == OFS_LOADS) begin
                    hrdata <= {21'h000000, shed_cnt_reg, 2'h0, relay_reg};
                end else if (haddr[7:0] >= OFS_LEARN && haddr[7:0] < OFS_LEARN + 8'h18) begin
                    hrdata <= {24'h000000, learn_reg[3'((haddr[7:0] - OFS_LEARN) >> 2)]};
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_pend_reg && wr_addr_reg == OFS_CTRL) begin
            ctrl_reg <= hwdata[1:0];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    split_all_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == ST_RUN && src_reg == SRC_SPLIT && !src_change) |=> relay_drive == 6'h3f)
        else $error("split service left a load off");
    delay_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == ST_DELAY |-> relay_drive == 6'h00)
        else $error("load on during start-up delay");
    change_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        src_change |=> relay_drive == 6'h00 && state_reg == ST_DELAY && sec_reg == 8'h00)
        else $error("source change did not restart delay");
    delay_spin_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == ST_DELAY && $past(hresetn)) |=> display.meter_mode == MTR_SPIN)
        else $error("meter not spinning in delay");
    ramp_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == ST_RAMP && !src_change) |=>
        $countones(relay_drive) == $countones($past(relay_drive)) + ($past(tick_reg) ? 1 : 0))
        else $error("ramp did not add exactly one load per second");
    shed_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == ST_RUN && managed && tick_reg && over && shed_cnt_reg != 3'h6 && !src_change) |=>
        $countones(relay_drive) + 1 == $countones($past(relay_drive)))
        else $error("overload did not shed one load");
    hold_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hold_reg[0] != 8'h00 |-> !relay_drive[0])
        else $error("held load energised");
    no_room_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == ST_RUN && managed && tick_reg && !over && shed_cnt_reg != 3'h0
         && headroom < learn_reg[top_idx] && !src_change) |=> $stable(relay_drive))
        else $error("load restored without headroom");
    lim20_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src_reg == SRC_SHORE && limit20_reg) |-> limit == 8'h14)
        else $error("lowered shore limit not 20 A");
    link_ok_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(hresetn) |-> link_good_indicator && !link_fault_indicator)
        else $error("link indicators wrong");
    tick_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tick_reg |=> !tick_reg)
        else $error("tick longer than one cycle");
    ramp_done_c: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == ST_RAMP ##1 state_reg == ST_RUN);
    shed_c: cover property (@(posedge hclk) disable iff (!hresetn) learn_pend_reg && tick_reg);
    restore_c: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == ST_RUN && managed && $rose(relay_drive[0]));
    split_c: cover property (@(posedge hclk) disable iff (!hresetn)
        src_reg == SRC_SPLIT && state_reg == ST_RUN);
endmodule
`default_nettype wire

// >>> plsc_partner.sv
// Partner model: switched loads behind the relays and the neutral current sensor
`timescale 1ns/1ns
`default_nettype none
module plsc_partner (
    input wire logic hclk,
    input wire logic [5:0] relay_drive,
    input wire logic [7:0] base_amps,
    output logic [7:0] current_amps
);
    // ************************************************************
    // Load draws and sensor
    // ************************************************************
    // Six loads; their sum stays under the 30 A limit on purpose
    localparam logic [7:0] DRAW [6] = '{8'h06, 8'h05, 8'h04, 8'h03, 8'h03, 8'h03};
    logic [7:0] sum_amps;
    always_comb begin
        sum_amps = base_amps;
        for (int i = 0; i < 6; i++) begin
            if (relay_drive[i]) begin
                sum_amps = sum_amps + DRAW[i];
            end
        end
    end
    // Sensor lags one clock, like a sampled meter
    always_ff @(posedge hclk) begin
        current_amps <= sum_amps;
    end
endmodule
`default_nettype wire

// >>> power_load_shed_controller_tb.sv
// Testbench of the power load shed controller
`timescale 1ns/1ns
`default_nettype none
module power_load_shed_controller_tb;
    import plsc_pkg::*;
    // ************************************************************
    // Bench, drivers and checks
    // ************************************************************
    localparam int TK = 10;
    logic hclk, hresetn, hsel, hwrite, sel_pulse, hreadyout, hresp, link_good, link_fault, seen;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] cur, base;
    logic [5:0] relays;
    plsc_line_s lines;
    plsc_display_s disp;
    int err_total, cmp_count, k;

    plsc_ctrl #(.TICK_CYCLES(TK)) plsc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lines(lines), .current_amps(cur),
        .service_select_pulse(sel_pulse), .relay_drive(relays), .display(disp),
        .link_good_indicator(link_good), .link_fault_indicator(link_fault));
    plsc_partner plsc_partner_i (.hclk(hclk), .relay_drive(relays), .base_amps(base), .current_amps(cur));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // Expected sensor reading for a base draw and a relay pattern
    function automatic logic [7:0] exp_cur(input logic [7:0] b, input logic [5:0] r);
        logic [7:0] d [6];
        d = '{8'h06, 8'h05, 8'h04, 8'h03, 8'h03, 8'h03};
        exp_cur = b;
        for (int i = 0; i < 6; i++) if (r[i]) exp_cur = exp_cur + d[i];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Single AHB-Lite word transfer; each phase ends at a rising edge with hready high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'b010;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask

    // Returns cycles until relays match, or n+1 if they never do
    task automatic wait_rel(input logic [5:0] e, input int n, output int kk);
        kk = 0;
        do begin
            @(negedge hclk);
            kk++;
        end while (relays !== e && kk <= n);
        @(posedge hclk);
    endtask

    task automatic power_up(input logic ramp);
        logic [2:0] sp;
        repeat (115 * TK) @(posedge hclk);
        @(negedge hclk);
        chk(relays, 6'h00);
        chk(disp.meter_mode, MTR_SPIN);
        sp = disp.spin_phase;
        repeat (TK) @(negedge hclk);
        chk(disp.spin_phase, (sp == 3'h5) ? 3'h0 : sp + 3'h1);
        @(posedge hclk);
        for (int i = 0; i < 6 && ramp; i++) begin
            wait_rel(6'((2 << i) - 1), i == 0 ? 10 * TK : TK, k);
            chk(i == 0 ? (k <= 10 * TK) : (k == TK), 1'b1);
        end
        wait_rel(6'h3f, 20 * TK, k);
        chk(k <= 20 * TK, 1'b1);
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        summarize();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        sel_pulse = 1'b0;
        lines = 4'h0;
        base = 8'h00;
        seed = 32'hc3d482af;
        err_total = 0;
        cmp_count = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk(relays, 6'h00);
        chk({link_good, link_fault}, 2'b10);
        @(posedge hclk);
        // Shore service; random base keeps total under 30 A
        seed = xs(seed);
        base <= seed[7:0] % 8'h06;
        lines <= 4'b1110;
        power_up(1'b1);
        @(negedge hclk);
        chk(disp.led_thirty_twenty, 1'b1);
        @(posedge hclk);
        base <= 8'h0a;
        wait_rel(6'h3e, 2 * TK, k);
        chk(k <= 2 * TK, 1'b1);
        repeat (15) @(posedge hclk);
        xfer(1'b0, OFS_LEARN, 32'h0);
        chk(rd, {24'h0, exp_cur(8'h00, 6'h01)});
        base <= 8'h00;
        seen = 1'b0;
        repeat (95 * TK) begin
            @(negedge hclk);
            seen = seen | disp.power_leds[0];
        end
        chk(relays, 6'h3e);
        chk(seen, 1'b1);
        @(posedge hclk);
        wait_rel(6'h3f, 40 * TK, k);
        chk(k <= 40 * TK, 1'b1);
        sel_pulse <= 1'b1;
        @(posedge hclk);
        sel_pulse <= 1'b0;
        wait_rel(6'h3e, 3 * TK, k);
        chk(k <= 3 * TK, 1'b1);
        $display("test shore done");
        // Split-phase service ignores any current
        lines <= 4'b1100;
        wait_rel(6'h00, 3, k);
        chk(k <= 3, 1'b1);
        power_up(1'b0);
        base <= 8'h28;
        repeat (20 * TK) @(posedge hclk);
        @(negedge hclk);
        chk(relays, 6'h3f);
        chk({disp.meter_mode, disp.led_fifty, disp.led_gen, disp.power_leds}, {MTR_BLANK, 2'b10, 6'h3f});
        @(posedge hclk);
        $display("test split done");
        // Generator service, first unmanaged, then managed at 45 A
        lines <= 4'b1111;
        wait_rel(6'h00, 3, k);
        chk(k <= 3, 1'b1);
        power_up(1'b0);
        repeat (5 * TK) @(posedge hclk);
        @(negedge hclk);
        chk({disp.meter_mode, disp.led_gen, disp.power_leds}, {MTR_CURRENT, 1'b1, 6'h3f});
        chk(disp.meter_value, exp_cur(8'h28, 6'h3f));
        @(posedge hclk);
        xfer(1'b1, OFS_CTRL, 32'h1);
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        wait_rel(6'h20, 12 * TK, k);
        chk(k <= 12 * TK, 1'b1);
        repeat (2 * TK) @(posedge hclk);
        xfer(1'b0, OFS_LOADS, 32'h0);
        chk(rd, 32'h520);
        xfer(1'b0, OFS_LEARN + 8'h04, 32'h0);
        chk(rd, {24'h0, exp_cur(8'h00, 6'h02)});
        xfer(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        $display("test generator done");
        // Reset in mid-run clears the relay drives at once
        hresetn <= 1'b0;
        @(negedge hclk);
        chk(relays, 6'h00);
        $display("test reset done");
        summarize();
    end
endmodule
`default_nettype wire
